// file: shared/tbs_pkg.sv
package tbs_pkg;
	localparam int NUM_CHAN = 9;
	localparam int IR_LEN = 8;
	// fixed pattern captured into the instruction register
	localparam logic [7:0] IR_CAPTURE = 8'h3D;
	// narrow chain opcodes (all-zero code is extest)
	localparam logic [7:0] N_EXTEST = 8'h00;
	localparam logic [7:0] N_SAMPLE = 8'h82;
	localparam logic [7:0] N_CLAMP = 8'h87;
	// wide chain opcodes
	localparam logic [7:0] W_EXTEST = 8'h99;
	localparam logic [7:0] W_SAMPLE = 8'h92;
	localparam logic [7:0] W_CLAMP = 8'h8F;
	localparam logic [7:0] OP_HIGHZ = 8'h06;
	localparam logic [7:0] IR_RESET = 8'hFF;
	// narrow: per channel tx in + rx out, plus the two enables; wide adds bus diff and pos drive
	localparam int NARROW_LEN = 2 * NUM_CHAN + 2;
	localparam int WIDE_LEN = 4 * NUM_CHAN + 2;
	localparam int PERIOD_NS = 4;
	localparam int TCK_MIN_NS = 10;
	localparam int TCK_MIN_CYC = (TCK_MIN_NS + PERIOD_NS - 1) / PERIOD_NS;

	typedef enum logic [3:0] {
		TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h3,
		TS_CAP_DR = 4'h2, TS_SHIFT_DR = 4'h6, TS_EXIT1_DR = 4'h7,
		TS_PAUSE_DR = 4'h5, TS_EXIT2_DR = 4'h4, TS_UPD_DR = 4'hC,
		TS_SEL_IR = 4'hD, TS_CAP_IR = 4'hF, TS_SHIFT_IR = 4'hE,
		TS_EXIT1_IR = 4'hA, TS_PAUSE_IR = 4'hB, TS_EXIT2_IR = 4'h9,
		TS_UPD_IR = 4'h8
	} tbs_tap_type;

	typedef enum logic [2:0] {
		INS_BYPASS = 3'h0, INS_EXTEST = 3'h1, INS_SAMPLE = 3'h2,
		INS_CLAMP = 3'h3, INS_HIGHZ = 3'h4
	} tbs_ins_type;
endpackage

// file: src/tbs_sync.sv
`timescale 1ns/1ps
module tbs_sync import tbs_pkg::*; #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule // tbs_sync

// file: src/tbs_ctrl.sv
`timescale 1ns/1ps
module tbs_ctrl import tbs_pkg::*; #(
	parameter bit WIDE_CHAIN = 1'b0
) (
	// clock and reset
	input  wire logic                clock_in,
	input  wire logic                reset_n_in,
	// logic side
	input  wire logic                tx_output_on_in,
	input  wire logic                rx_output_on_n_in,
	input  wire logic [NUM_CHAN-1:0] tx_logic_in,
	output logic      [NUM_CHAN-1:0] rx_logic_out,
	output logic      [NUM_CHAN-1:0] rx_logic_oe_out,
	// bus side, comparator result of pos minus neg
	input  wire logic [NUM_CHAN-1:0] bus_diff_in,
	output logic      [NUM_CHAN-1:0] bus_pos_pin_out,
	output logic      [NUM_CHAN-1:0] bus_neg_pin_out,
	output logic      [NUM_CHAN-1:0] bus_oe_out,
	// test access port
	input  wire logic                tck_in,
	input  wire logic                tms_in,
	input  wire logic                tdi_in,
	input  wire logic                trst_n_in,
	output logic                     tdo_out,
	output logic                     tdo_oe_out
);
	localparam int BLEN = WIDE_CHAIN ? WIDE_LEN : NARROW_LEN;
	localparam int SW = 2 * NUM_CHAN + 6;
	default clocking cb_sys @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	logic [SW-1:0] s_raw;
	logic [SW-1:0] s;
	assign s_raw = {trst_n_in, tdi_in, tms_in, tck_in, bus_diff_in,
		tx_logic_in, rx_output_on_n_in, tx_output_on_in};

	tbs_sync #(.WIDTH(SW)) u_sync (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.async_in   (s_raw),
		.sync_out   (s)
	);

	logic                tx_on, rx_on_n, tck, tms, tdi, trst_n;
	logic [NUM_CHAN-1:0] din, diff;
	assign tx_on = s[0];
	assign rx_on_n = s[1];
	assign din = s[NUM_CHAN+1:2];
	assign diff = s[2*NUM_CHAN+1:NUM_CHAN+2];
	assign tck = s[2*NUM_CHAN+2];
	assign tms = s[2*NUM_CHAN+3];
	assign tdi = s[2*NUM_CHAN+4];
	assign trst_n = s[SW-1];

	// state
	tbs_tap_type         st_reg, st_next;
	logic                tck_d_reg, tck_d_next;
	logic [IR_LEN-1:0]   irs_reg, irs_next, ir_reg, ir_next;
	logic                byp_reg, byp_next;
	logic [BLEN-1:0]     bsr_reg, bsr_next, upd_reg, upd_next;
	logic                tdo_reg, tdo_next, tdoe_reg, tdoe_next;
	logic [NUM_CHAN-1:0] rxo_reg, rxo_next, rxe_reg, rxe_next;
	logic [NUM_CHAN-1:0] bp_reg, bp_next, bn_reg, bn_next;
	logic [NUM_CHAN-1:0] boe_reg, boe_next;
	tbs_ins_type         ins;

	logic rise, fall;
	assign rise = tck & ~tck_d_reg;
	assign fall = ~tck & tck_d_reg;

	always_comb begin
		ins = INS_BYPASS;
		if (ir_reg == OP_HIGHZ)
			ins = INS_HIGHZ;
		else if (WIDE_CHAIN) begin
			if (ir_reg == W_EXTEST) ins = INS_EXTEST;
			else if (ir_reg == W_SAMPLE) ins = INS_SAMPLE;
			else if (ir_reg == W_CLAMP) ins = INS_CLAMP;
		end else begin
			if (ir_reg == N_EXTEST) ins = INS_EXTEST;
			else if (ir_reg == N_SAMPLE) ins = INS_SAMPLE;
			else if (ir_reg == N_CLAMP) ins = INS_CLAMP;
		end
	end

	logic use_bsr;
	assign use_bsr = (ins == INS_EXTEST) || (ins == INS_SAMPLE);
	// functional values before the scan cells
	logic [NUM_CHAN-1:0] f_dp, f_rx;
	logic                f_txe, f_rxe;
	assign f_rx = (tx_on && !rx_on_n) ? din : diff;
	assign f_dp = din;
	assign f_txe = tx_on;
	assign f_rxe = ~rx_on_n;

	// captured chain image; narrow, wide
	logic [BLEN-1:0] cap;
	always_comb begin
		cap = '0;
		cap[NUM_CHAN-1:0] = din;
		cap[2*NUM_CHAN-1:NUM_CHAN] = f_rx;
		cap[2*NUM_CHAN] = f_txe;
		cap[2*NUM_CHAN+1] = f_rxe;
		if (WIDE_CHAIN) begin
			cap[BLEN-1:BLEN-NUM_CHAN] = diff;
			cap[BLEN-NUM_CHAN-1:BLEN-2*NUM_CHAN] = f_dp;
		end
	end

	// tap state sequencing on test clock rises
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			TS_RESET:    st_next = tms ? TS_RESET : TS_IDLE;
			TS_IDLE:     st_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_DR:   st_next = tms ? TS_SEL_IR : TS_CAP_DR;
			TS_CAP_DR:   st_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_SHIFT_DR: st_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_EXIT1_DR: st_next = tms ? TS_UPD_DR : TS_PAUSE_DR;
			TS_PAUSE_DR: st_next = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
			TS_EXIT2_DR: st_next = tms ? TS_UPD_DR : TS_SHIFT_DR;
			TS_UPD_DR:   st_next = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_IR:   st_next = tms ? TS_RESET : TS_CAP_IR;
			TS_CAP_IR:   st_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_SHIFT_IR: st_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_EXIT1_IR: st_next = tms ? TS_UPD_IR : TS_PAUSE_IR;
			TS_PAUSE_IR: st_next = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
			TS_EXIT2_IR: st_next = tms ? TS_UPD_IR : TS_SHIFT_IR;
			TS_UPD_IR:   st_next = tms ? TS_SEL_DR : TS_IDLE;
			default:     st_next = TS_RESET;
		endcase
		if (!rise)
			st_next = st_reg;
		if (!trst_n)
			st_next = TS_RESET;
	end

	// scan registers act on rises, updates and tdo on falls
	always_comb begin
		irs_next = irs_reg;
		ir_next = ir_reg;
		byp_next = byp_reg;
		bsr_next = bsr_reg;
		upd_next = upd_reg;
		tdo_next = tdo_reg;
		tdoe_next = tdoe_reg;
		tck_d_next = tck;
		if (rise) begin
			case (st_reg)
				TS_CAP_IR:   irs_next = IR_CAPTURE;
				TS_SHIFT_IR: irs_next = {tdi, irs_reg[IR_LEN-1:1]};
				TS_CAP_DR: begin
					byp_next = 1'b0;
					if (use_bsr) bsr_next = cap;
				end
				TS_SHIFT_DR: begin
					byp_next = tdi;
					if (use_bsr) bsr_next = {tdi, bsr_reg[BLEN-1:1]};
				end
				default: ;
			endcase
		end
		if (fall) begin
			case (st_reg)
				TS_UPD_IR: ir_next = irs_reg;
				TS_UPD_DR: if (use_bsr) upd_next = bsr_reg;
				TS_RESET:  ir_next = IR_RESET;
				default: ;
			endcase
			tdoe_next = (st_reg == TS_SHIFT_IR) ||
				(st_reg == TS_SHIFT_DR);
			tdo_next = (st_reg == TS_SHIFT_IR) ? irs_reg[0] :
				(use_bsr ? bsr_reg[0] : byp_reg);
		end
		if (!trst_n) begin
			ir_next = IR_RESET;
			tdoe_next = 1'b0;
		end
	end

	// pin drive, chosen by instruction
	always_comb begin
		logic                t_txe, t_rxe;
		logic [NUM_CHAN-1:0] t_d, t_r;
		t_txe = f_txe;
		t_rxe = f_rxe;
		t_d = f_dp;
		t_r = f_rx;
		if (ins == INS_EXTEST || ins == INS_CLAMP) begin
			t_d = upd_reg[NUM_CHAN-1:0];
			t_r = upd_reg[2*NUM_CHAN-1:NUM_CHAN];
			t_txe = upd_reg[2*NUM_CHAN];
			t_rxe = upd_reg[2*NUM_CHAN+1];
		end
		if (ins == INS_HIGHZ) begin
			t_txe = 1'b0;
			t_rxe = 1'b0;
		end
		// driver mode; receiver mode; both float
		// positive copies input, negative its complement
		bp_next = t_d;
		bn_next = ~t_d;
		boe_next = {NUM_CHAN{t_txe}};
		rxo_next = t_r;
		rxe_next = {NUM_CHAN{t_rxe}};
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_reg <= TS_RESET;
			tck_d_reg <= 1'b0;
			irs_reg <= '0;
			ir_reg <= IR_RESET;
			byp_reg <= 1'b0;
			bsr_reg <= '0;
			upd_reg <= '0;
			tdo_reg <= 1'b0;
			tdoe_reg <= 1'b0;
			rxo_reg <= '0;
			rxe_reg <= '0;
			bp_reg <= '0;
			bn_reg <= '1;
			boe_reg <= '0;
		end else begin
			st_reg <= st_next;
			tck_d_reg <= tck_d_next;
			irs_reg <= irs_next;
			ir_reg <= ir_next;
			byp_reg <= byp_next;
			bsr_reg <= bsr_next;
			upd_reg <= upd_next;
			tdo_reg <= tdo_next;
			tdoe_reg <= tdoe_next;
			rxo_reg <= rxo_next;
			rxe_reg <= rxe_next;
			bp_reg <= bp_next;
			bn_reg <= bn_next;
			boe_reg <= boe_next;
		end
	end

	assign rx_logic_out = rxo_reg;
	assign rx_logic_oe_out = rxe_reg;
	assign bus_pos_pin_out = bp_reg;
	assign bus_neg_pin_out = bn_reg;
	assign bus_oe_out = boe_reg;
	assign tdo_out = tdo_reg;
	assign tdo_oe_out = tdoe_reg;
	sequence s_cap_ir;
		rise && st_reg == TS_CAP_IR;
	endsequence
	sequence s_cap_dr;
		rise && st_reg == TS_CAP_DR;
	endsequence
	sequence s_shift_dr;
		rise && st_reg == TS_SHIFT_DR;
	endsequence

	a_ir_capture: assert property (s_cap_ir and trst_n |=>
		irs_reg == IR_CAPTURE) else $error("ir capture wrong");
	a_bypass_zero: assert property (s_cap_dr and trst_n |=>
		!byp_reg) else $error("bypass capture not zero");
	a_bypass_shift: assert property (s_shift_dr |=>
		byp_reg == $past(tdi)) else $error("bypass shift wrong");
	a_drv_mode: assert property (ins == INS_BYPASS && tx_on &&
		rx_on_n |=> &boe_reg && !(|rxe_reg)) else $error("drv mode");
	a_rcv_mode: assert property (ins == INS_BYPASS && !tx_on &&
		!rx_on_n |=> !(|boe_reg) && &rxe_reg) else $error("rcv mode");
	a_tri_mode: assert property (ins == INS_BYPASS && !tx_on &&
		rx_on_n |=> !(|boe_reg) && !(|rxe_reg)) else $error("tri mode");
	a_loop_mode: assert property (ins == INS_BYPASS && tx_on &&
		!rx_on_n |=> rxo_reg == $past(din)) else $error("loop mode");
	a_drv_compl: assert property (bn_reg == ~bp_reg)
		else $error("negative not complement");
	a_tap_reset: assert property (!trst_n |=> st_reg == TS_RESET)
		else $error("test reset ignored");
endmodule // tbs_ctrl

// file: tb/tbs_tap_drv.sv
`timescale 1ns/1ps
module tbs_tap_drv (
	// clock
	input  wire logic clock_in,
	// test access port
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	output logic      trst_n_out,
	input  wire logic tdo_in
);
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		trst_n_out = 1'b1;
	end

	// one tck period of 12 clocks, tdo read while tck low
	task automatic clk_bit(input logic m, input logic d, output logic q);
		@(posedge clock_in);
		tms_out <= m;
		tdi_out <= d;
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
		q = tdo_in;
		@(posedge clock_in);
		tck_out <= 1'b1;
		repeat (6) @(posedge clock_in);
		tck_out <= 1'b0;
		// released line shows the inverse, not the last value
		tdi_out <= ~d;
	endtask

	// five ones reach test-logic-reset, then idle
	task automatic reset_tap();
		logic q;
		repeat (5) clk_bit(1'b1, 1'b0, q);
		clk_bit(1'b0, 1'b0, q);
	endtask

	task automatic trst_pulse();
		logic q;
		@(posedge clock_in);
		trst_n_out <= 1'b0;
		repeat (6) @(posedge clock_in);
		trst_n_out <= 1'b1;
		repeat (6) @(posedge clock_in);
		clk_bit(1'b0, 1'b0, q);
	endtask

	// idle to shift, n bits lsb first, update, back to idle
	task automatic shift(input logic ir, input int n,
		input logic [63:0] din, output logic [63:0] dout);
		logic q;
		dout = '0;
		clk_bit(1'b1, 1'b0, q);
		if (ir) begin
			clk_bit(1'b1, 1'b0, q);
		end
		clk_bit(1'b0, 1'b0, q);
		clk_bit(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			clk_bit(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk_bit(1'b1, 1'b0, q);
		clk_bit(1'b0, 1'b0, q);
	endtask
endmodule // tbs_tap_drv

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
	import tbs_pkg::*;
	logic                clock_in;
	logic                reset_n_in;
	logic                tx_on;
	logic                rx_on_n;
	logic [NUM_CHAN-1:0] tx_d;
	logic [NUM_CHAN-1:0] diff;
	logic [NUM_CHAN-1:0] rx_d;
	logic [NUM_CHAN-1:0] rx_oe;
	logic [NUM_CHAN-1:0] pos;
	logic [NUM_CHAN-1:0] neg;
	logic [NUM_CHAN-1:0] b_oe;
	logic                tck;
	logic                tms;
	logic                tdi;
	logic                trst_n;
	logic                tdo;
	logic                tdo_w;
	logic                tdo_oe;
	logic                use_wide;
	int                  err_count;
	int                  cmp_count;

	tbs_ctrl #(.WIDE_CHAIN(1'b0)) i_tbs_ctrl (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.tx_output_on_in(tx_on), .rx_output_on_n_in(rx_on_n),
		.tx_logic_in(tx_d), .rx_logic_out(rx_d),
		.rx_logic_oe_out(rx_oe), .bus_diff_in(diff),
		.bus_pos_pin_out(pos), .bus_neg_pin_out(neg),
		.bus_oe_out(b_oe), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo),
		.tdo_oe_out(tdo_oe)
	);

	// wide variant shares every input, only its tdo is watched
	tbs_ctrl #(.WIDE_CHAIN(1'b1)) i_tbs_ctrl_wide (
		.clock_in(clock_in), .reset_n_in(reset_n_in),
		.tx_output_on_in(tx_on), .rx_output_on_n_in(rx_on_n),
		.tx_logic_in(tx_d), .rx_logic_out(),
		.rx_logic_oe_out(), .bus_diff_in(diff),
		.bus_pos_pin_out(), .bus_neg_pin_out(),
		.bus_oe_out(), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo_w),
		.tdo_oe_out()
	);

	tbs_tap_drv i_tbs_tap_drv (
		.clock_in(clock_in), .tck_out(tck), .tms_out(tms),
		.tdi_out(tdi), .trst_n_out(trst_n),
		.tdo_in(use_wide ? tdo_w : tdo)
	);

	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// all four enable pairs, data differs from bus side
	task automatic test_modes();
		logic [1:0] m;
		logic [8:0] d;
		for (int k = 0; k < 4; k++) begin
			m = k[1:0];
			d = 9'h155 ^ {9{m[0]}};
			@(posedge clock_in);
			tx_on <= m[1];
			rx_on_n <= m[0];
			tx_d <= d;
			diff <= 9'h0CA;
			repeat (8) @(posedge clock_in);
			check("bus_oe", b_oe, {9{m[1]}});
			check("rx_oe", rx_oe, {9{~m[0]}});
			if (m[1]) begin
				check("pos", pos, d);
				check("neg", neg, 9'(~d));
			end
			if (!m[0]) begin
				check("rx", rx_d, m[1] ? d : 9'h0CA);
			end
		end
	endtask

	task automatic test_ir_bypass();
		logic [63:0] q;
		i_tbs_tap_drv.reset_tap();
		i_tbs_tap_drv.shift(1'b1, IR_LEN, 64'h0000_0000_0000_0055, q);
		check("ir_capture", q[7:0], IR_CAPTURE);
		i_tbs_tap_drv.shift(1'b0, 8, 64'h0000_0000_0000_00B3, q);
		check("bypass", q[7:0], 8'h66);
		check("tdo_oe_idle", tdo_oe, 1'b0);
	endtask

	// chain length found from where a lone one comes out
	task automatic test_decode();
		logic [7:0]  ops [5] = '{N_EXTEST, N_SAMPLE, N_CLAMP, OP_HIGHZ,
			8'hA5};
		int          lens [5] = '{NARROW_LEN, NARROW_LEN, 1, 1, 1};
		logic [63:0] q;
		@(posedge clock_in);
		tx_on <= 1'b1;
		rx_on_n <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			i_tbs_tap_drv.shift(1'b1, IR_LEN, {56'h0, ops[k]}, q);
			i_tbs_tap_drv.shift(1'b0, 64, 64'h0000_0100_0000_0000, q);
			check("len", {q[40+lens[k]], q[39+lens[k]]}, 2'b10);
			if (k == 3) begin
				check("hz_bus", b_oe, 9'h000);
				check("hz_rx", rx_oe, 9'h000);
			end
		end
	endtask

	task automatic test_trst();
		logic [63:0] q;
		i_tbs_tap_drv.shift(1'b1, IR_LEN, {56'h0, N_SAMPLE}, q);
		i_tbs_tap_drv.trst_pulse();
		i_tbs_tap_drv.shift(1'b0, 8, 64'h0000_0000_0000_00B3, q);
		check("trst_ir", q[7:0], 8'h66);
	endtask

	// wide chain: bus cells lengthen the scan path
	task automatic test_wide();
		logic [7:0]  ops [5] = '{W_EXTEST, W_SAMPLE, W_CLAMP, OP_HIGHZ,
			N_SAMPLE};
		int          lens [5] = '{WIDE_LEN, WIDE_LEN, 1, 1, 1};
		logic [63:0] q;
		int          p;
		@(posedge clock_in);
		use_wide <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			i_tbs_tap_drv.shift(1'b1, IR_LEN, {56'h0, ops[k]}, q);
			i_tbs_tap_drv.shift(1'b0, 64, 64'h0000_0000_0010_0000, q);
			p = 20 + lens[k];
			check("wlen", {q[p], q[p-1]}, 2'b10);
		end
	endtask

	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	initial begin
		repeat (60000) @(posedge clock_in);
		err_count++;
		print_verdict();
	end

	initial begin
		err_count = 0;
		cmp_count = 0;
		reset_n_in = 1'b0;
		tx_on = 1'b0;
		rx_on_n = 1'b1;
		use_wide = 1'b0;
		tx_d = '0;
		diff = '0;
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		test_modes();
		test_ir_bypass();
		test_decode();
		test_trst();
		test_wide();
		print_verdict();
	end
endmodule // tb
